// [src/ttu_pkg.sv]
package ttu_pkg;
  // apb address width, counter width
  localparam int unsigned TTU_ADDR_W = 12;
  localparam int unsigned TTU_CNT_W = 16;
  // register indices; byte address is four times the index
  localparam logic [9:0] TTU_T0_TALLY_IDX = 10'h050;
  localparam logic [9:0] TTU_T0_LIMA_IDX = 10'h052;
  localparam logic [9:0] TTU_T0_LIMB_IDX = 10'h054;
  localparam logic [9:0] TTU_T0_CTRL_IDX = 10'h056;
  localparam logic [9:0] TTU_T1_TALLY_IDX = 10'h058;
  localparam logic [9:0] TTU_T1_LIMA_IDX = 10'h05a;
  localparam logic [9:0] TTU_T1_LIMB_IDX = 10'h05c;
  localparam logic [9:0] TTU_T1_CTRL_IDX = 10'h05e;
  localparam logic [9:0] TTU_T2_TALLY_IDX = 10'h060;
  localparam logic [9:0] TTU_T2_LIMA_IDX = 10'h062;
  localparam logic [9:0] TTU_T2_CTRL_IDX = 10'h066;
  // register kinds returned by the address decoder
  localparam logic [1:0] TTU_K_TALLY = 2'h0;
  localparam logic [1:0] TTU_K_LIMA = 2'h1;
  localparam logic [1:0] TTU_K_LIMB = 2'h2;
  localparam logic [1:0] TTU_K_CTRL = 2'h3;
  // mode/control word field positions
  localparam int unsigned TTU_EN_B = 15;
  localparam int unsigned TTU_GATE_B = 14;
  localparam int unsigned TTU_INT_B = 13;
  localparam int unsigned TTU_RIU_B = 12;
  localparam int unsigned TTU_MC_B = 5;
  localparam int unsigned TTU_RTG_B = 4;
  localparam int unsigned TTU_PRE_B = 3;
  localparam int unsigned TTU_EXT_B = 2;
  localparam int unsigned TTU_ALT_B = 1;
  localparam int unsigned TTU_FREE_RUN_SELECT_B = 0;
  // reset values: dual-limit mode on for timers 0 and 1, pins high
  localparam logic [2:0] TTU_ALT_RST = 3'h3;
  localparam logic [1:0] TTU_OUT_RST = 2'h3;
  // each timer is serviced once every four cpu clocks
  localparam int unsigned TTU_SERVICE_DIV = 4;
  localparam logic [1:0] TTU_SVC_LAST = 2'(TTU_SERVICE_DIV - 1);
endpackage : ttu_pkg

// [src/ttu_timer_unit.sv]
// Notes on behaviour
// - run-enable clear stops counting; input pin transitions then ignored.
// - free-run clear: run-enable self-clears at maximum count.
// - control write changes run-enable only with gate bit set; gate reads 0.
// - interrupt-on-terminal set: request at every terminal, both limits in dual mode.
// - an issued request stays latched downstream even if enable later cleared.
// - active-limit indicator shows limit in use; not writable; zero without dual mode.
// - limit-reached flag set at each maximum count; only software clears it.
// - edge-restart select only matters with internal clocking.
// - gated mode counts while pin high, holds while low; pin may be asynchronous.
// - edge-restart: rising edge starts, clears to zero, later edges clear again.
// - chained bit chooses quarter cpu clock or timer 2 output as clock.
// - outside-clock select counts pin rising edges; else pin is control.
// - output reacts within 6 clocks; edges 4 clocks apart all counted.
// - dual mode alternates limits A and B at each maximum count; else A.
// - single mode pulses out low one clock; dual mode out low while B.
// - free-run runs on; else halts at max, dual mode after A then B.
// - timer 2 has dual, outside, chained, edge-restart and indicator fixed zero.
// - count readable and writable anytime; write acts in current count cycle.
// - reset only on equality with limit; else wrap through 0xffff.
// - reset clears run-enable, indicator; sets dual mode; out pins go high.
// - count returns to zero on the limit clock; limit never held.
// - every timer register access adds one wait state.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module ttu_timer_unit
(
  // clock, reset, clock enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ttu_pkg::TTU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins of timers 0 and 1
  input wire logic [1:0] timerIn,
  output logic [1:0] timerOut,
  // terminal-count requests to the interrupt controller
  output logic [2:0] timerIrq
);
  import ttu_pkg::*;

  // address decode: {hit, timer, kind}
  function automatic logic [4:0] ttuDecode(input logic [TTU_ADDR_W-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a[1:0] == 2'h0)
    begin
      case (a[TTU_ADDR_W-1:2])
        TTU_T0_TALLY_IDX: r = {1'b1, 2'h0, TTU_K_TALLY};
        TTU_T0_LIMA_IDX: r = {1'b1, 2'h0, TTU_K_LIMA};
        TTU_T0_LIMB_IDX: r = {1'b1, 2'h0, TTU_K_LIMB};
        TTU_T0_CTRL_IDX: r = {1'b1, 2'h0, TTU_K_CTRL};
        TTU_T1_TALLY_IDX: r = {1'b1, 2'h1, TTU_K_TALLY};
        TTU_T1_LIMA_IDX: r = {1'b1, 2'h1, TTU_K_LIMA};
        TTU_T1_LIMB_IDX: r = {1'b1, 2'h1, TTU_K_LIMB};
        TTU_T1_CTRL_IDX: r = {1'b1, 2'h1, TTU_K_CTRL};
        TTU_T2_TALLY_IDX: r = {1'b1, 2'h2, TTU_K_TALLY};
        TTU_T2_LIMA_IDX: r = {1'b1, 2'h2, TTU_K_LIMA};
        TTU_T2_CTRL_IDX: r = {1'b1, 2'h2, TTU_K_CTRL};
        default: r = 5'h00;
      endcase
    end
    return r;
  endfunction : ttuDecode

  logic [1:0] divQ;
  logic [TTU_CNT_W-1:0] tallyQ [3];
  logic [TTU_CNT_W-1:0] limAQ [3];
  logic [TTU_CNT_W-1:0] limBQ [2];
  logic [TTU_CNT_W-1:0] nxt [3];
  logic [TTU_CNT_W-1:0] lim [3];
  logic [2:0] enQ, intQ, riuQ, mcQ, rtgQ, preQ, extQ, altQ, contQ, startQ;
  logic [2:0] syncQ [2];
  logic [1:0] lvlQ, rise;
  logic [2:0] tick, term, restart, wrCtrl, wrTally, wrLimA, altD, riuD;
  logic [1:0] wrLimB;
  logic [4:0] dec;
  logic hit, wrAcc, slot;
  logic [1:0] tSel, kind;
  logic [15:0] rdData;

  // bus decode and write strobes; a write lands on the edge that samples pready
  always_comb
  begin
    dec = ttuDecode(paddr);
    hit = dec[4];
    tSel = dec[3:2];
    kind = dec[1:0];
    wrAcc = psel && penable && pready && pwrite && hit;
    for (int i = 0; i < 3; i++)
    begin
      wrCtrl[i] = wrAcc && (tSel == 2'(i)) && (kind == TTU_K_CTRL);
      wrTally[i] = wrAcc && (tSel == 2'(i)) && (kind == TTU_K_TALLY);
      wrLimA[i] = wrAcc && (tSel == 2'(i)) && (kind == TTU_K_LIMA);
    end
    for (int i = 0; i < 2; i++)
      wrLimB[i] = wrAcc && (tSel == 2'(i)) && (kind == TTU_K_LIMB);
  end

  // read mux; the gate bit is never stored so it reads zero
  always_comb
  begin
    rdData = 16'h0000;
    if (hit && tSel != 2'h3)
    begin
      case (kind)
        TTU_K_TALLY: rdData = tallyQ[tSel];
        TTU_K_LIMA: rdData = limAQ[tSel];
        TTU_K_LIMB: rdData = (tSel[1]) ? 16'h0000 : limBQ[tSel[0]];
        TTU_K_CTRL:
        begin
          rdData[TTU_EN_B] = enQ[tSel];
          rdData[TTU_GATE_B] = 1'b0;
          rdData[TTU_INT_B] = intQ[tSel];
          rdData[TTU_RIU_B] = riuQ[tSel];
          rdData[TTU_MC_B] = mcQ[tSel];
          rdData[TTU_RTG_B] = rtgQ[tSel];
          rdData[TTU_PRE_B] = preQ[tSel];
          rdData[TTU_EXT_B] = extQ[tSel];
          rdData[TTU_ALT_B] = altQ[tSel];
          rdData[TTU_FREE_RUN_SELECT_B] = contQ[tSel];
        end
        default: rdData = 16'h0000;
      endcase
    end
  end

  // apb answer: one wait cycle lets the count pipeline settle before data
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      if (pready)
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      else if (psel && penable)
      begin
        pready <= 1'b1;
        pslverr <= !hit;
        prdata <= (hit && !pwrite) ? {16'h0000, rdData} : 32'h00000000;
      end
    end
  end

  // service slot every fourth clock
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      divQ <= 2'h0;
    else if (clkEn)
      divQ <= divQ + 2'h1;
  end

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      syncQ[0] <= 3'h0;
      syncQ[1] <= 3'h0;
      lvlQ <= 2'h0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        syncQ[i] <= {syncQ[i][1:0], timerIn[i]};
        if (syncQ[i][1] == syncQ[i][2])
          lvlQ[i] <= syncQ[i][2];
      end
    end
  end

  // tick, terminal and restart decisions; timer 2 first since 0 and 1 chain on it
  always_comb
  begin
    slot = (divQ == TTU_SVC_LAST);
    for (int i = 0; i < 3; i++)
      nxt[i] = tallyQ[i] + 16'h0001;
    // edges seen while disabled are dropped, not stored
    for (int i = 0; i < 2; i++)
      rise[i] = (syncQ[i][1] == syncQ[i][2]) && syncQ[i][2] && !lvlQ[i] && enQ[i];
    lim[2] = limAQ[2];
    tick[2] = enQ[2] && slot;
    restart[2] = 1'b0;
    term[2] = tick[2] && (nxt[2] == lim[2]);
    for (int i = 0; i < 2; i++)
    begin
      lim[i] = riuQ[i] ? limBQ[i] : limAQ[i];
      restart[i] = !extQ[i] && rtgQ[i] && rise[i];
      // outside clocking counts edges at once, not at the slot, to keep latency low
      if (extQ[i])
        tick[i] = rise[i];
      else
        tick[i] = enQ[i] && (preQ[i] ? term[2] : slot)
          && (rtgQ[i] ? startQ[i] : lvlQ[i]);
      term[i] = tick[i] && !restart[i] && (nxt[i] == lim[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      altD[i] = wrCtrl[i] ? (pwdata[TTU_ALT_B] && i != 2) : altQ[i];
      riuD[i] = altD[i] && (term[i] ? !riuQ[i] : riuQ[i]);
    end
  end

  // count and limit registers; a software write wins over the tick
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        tallyQ[i] <= 16'h0000;
        limAQ[i] <= 16'h0000;
      end
      limBQ[0] <= 16'h0000;
      limBQ[1] <= 16'h0000;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wrTally[i])
          tallyQ[i] <= pwdata[15:0];
        else if (restart[i] || term[i])
          tallyQ[i] <= 16'h0000;
        else if (tick[i])
          tallyQ[i] <= nxt[i];
        if (wrLimA[i])
          limAQ[i] <= pwdata[15:0];
      end
      for (int i = 0; i < 2; i++)
        if (wrLimB[i])
          limBQ[i] <= pwdata[15:0];
    end
  end

  // mode/control bits; timer 2 keeps its missing modes at zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      enQ <= 3'h0;
      intQ <= 3'h0;
      riuQ <= 3'h0;
      mcQ <= 3'h0;
      rtgQ <= 3'h0;
      preQ <= 3'h0;
      extQ <= 3'h0;
      altQ <= TTU_ALT_RST;
      contQ <= 3'h0;
      startQ <= 3'h0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wrCtrl[i])
        begin
          intQ[i] <= pwdata[TTU_INT_B];
          rtgQ[i] <= pwdata[TTU_RTG_B] && i != 2;
          preQ[i] <= pwdata[TTU_PRE_B] && i != 2;
          extQ[i] <= pwdata[TTU_EXT_B] && i != 2;
          contQ[i] <= pwdata[TTU_FREE_RUN_SELECT_B];
        end
        altQ[i] <= altD[i];
        riuQ[i] <= riuD[i];
        // a gated write beats the self-clear in the same cycle
        if (wrCtrl[i] && pwdata[TTU_GATE_B])
          enQ[i] <= pwdata[TTU_EN_B];
        else if (term[i] && !contQ[i] && (!altQ[i] || riuQ[i]))
          enQ[i] <= 1'b0;
        // hardware set wins over a software clear
        mcQ[i] <= (wrCtrl[i] ? pwdata[TTU_MC_B] : mcQ[i]) || term[i];
        if (!enQ[i])
          startQ[i] <= 1'b0;
        else if (restart[i])
          startQ[i] <= 1'b1;
      end
    end
  end

  // output pins and interrupt pulses, both registered
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      timerOut <= TTU_OUT_RST;
      timerIrq <= 3'h0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < 2; i++)
        timerOut[i] <= altD[i] ? !riuD[i] : !term[i];
      // a pulse once sent is never withdrawn; the controller latches it
      timerIrq <= term & intQ;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_halt_no_count: assert property (
    clkEn && !enQ[0] && !wrTally[0] |=> tallyQ[0] == $past(tallyQ[0]))
    else $error("count moved while disabled");
  a_auto_stop_single: assert property (
    clkEn && term[0] && !contQ[0] && !altQ[0] && !wrCtrl[0] |=> !enQ[0])
    else $error("run-enable not cleared at maximum count");
  a_gate_reads_zero: assert property (
    pready && !pwrite && !pslverr && kind == TTU_K_CTRL |-> !prdata[TTU_GATE_B])
    else $error("gate bit read as one");
  a_irq_on_term: assert property (
    clkEn && term[1] && intQ[1] |=> timerIrq[1])
    else $error("missing interrupt request at terminal");
  a_riu_alt_off: assert property (
    !altQ[0] |-> !riuQ[0])
    else $error("active-limit set with dual mode off");
  a_flag_set_term: assert property (
    clkEn && term[2] |=> mcQ[2])
    else $error("limit-reached flag not set");
  a_zero_after_limit: assert property (
    clkEn && term[0] && !wrTally[0] |=> tallyQ[0] == 16'h0000)
    else $error("count not zero after limit");
  a_single_pulse_out: assert property (
    clkEn && term[1] && !altD[1] ##1 clkEn |-> !timerOut[1] ##1 timerOut[1])
    else $error("output pulse not one clock low");
  a_one_wait_state: assert property (
    $rose(penable) && psel && clkEn |-> !pready ##1 pready)
    else $error("access not answered after one wait state");
  a_timer2_fixed: assert property (
    !riuQ[2] && !altQ[2] && !extQ[2] && !preQ[2] && !rtgQ[2])
    else $error("timer 2 fixed mode bits set");
  a_restart_clear: assert property (
    clkEn && restart[1] && !wrTally[1] |=> tallyQ[1] == 16'h0000 && startQ[1])
    else $error("edge restart did not clear count");

  c_dual_limit_b: cover property (term[0] && altQ[0] && riuQ[0]);
  c_irq_timer1: cover property (timerIrq[1]);
  c_edge_restart: cover property (restart[1]);
  c_chained_tick: cover property (term[2] && tick[0] && preQ[0]);
endmodule : ttu_timer_unit

// [dv/ttu_pin_source.sv]
`timescale 1ns/1ps
module ttu_pin_source
(
  // clock
  input wire logic sys_clk,
  // requests from the bench
  input wire logic [1:0] levelHold,
  input wire logic [1:0] pulseGo,
  // pins towards the timers
  output logic [1:0] pinOut
);
  logic [2:0] phaseQ [2] = '{3'h0, 3'h0};

  // a pulse is two clocks high then at least three low, never faster than five clocks
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (phaseQ[i] != 3'h0)
        phaseQ[i] <= phaseQ[i] - 3'h1;
      else if (pulseGo[i])
        phaseQ[i] <= 3'h4;
    end
  end

  // a held level wins over pulses; the pins are never left floating
  always_comb pinOut = levelHold | {phaseQ[1] > 3'h2, phaseQ[0] > 3'h2};
endmodule : ttu_pin_source

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import ttu_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [TTU_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] timerIn;
  logic [1:0] timerOut;
  logic [2:0] timerIrq;
  logic [1:0] levelHold = 2'h0;
  logic [1:0] pulseGo = 2'h0;
  logic [31:0] rdVal;
  logic rdErr;
  int errorCnt = 0;
  int checked = 0;
  int irqCnt [3] = '{0, 0, 0};
  int lowCnt = 0;
  int irqBase = 0;

  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  ttu_timer_unit i_dut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerIn(timerIn), .timerOut(timerOut),
    .timerIrq(timerIrq));

  ttu_pin_source i_src (.sys_clk(sys_clk), .levelHold(levelHold), .pulseGo(pulseGo),
    .pinOut(timerIn));

  // tally request pulses and single-mode low cycles of timer 0
  always @(posedge sys_clk)
  begin
    if (!reset)
    begin
      for (int i = 0; i < 3; i++)
        if (timerIrq[i] === 1'b1)
          irqCnt[i]++;
      if (timerOut[0] === 1'b0)
        lowCnt++;
    end
  end

  task automatic printVerdict;
    if (errorCnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : printVerdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge, leaves an idle cycle behind
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    chk("access cycles", n, 2);
  endtask : apb

  task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk($sformatf("reg %h", idx), rdVal, {16'h0000, exp});
  endtask : rd

  task automatic edges(input int ch, input int num);
    repeat (num)
    begin
      pulseGo[ch] <= 1'b1;
      @(posedge sys_clk);
      pulseGo[ch] <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask : edges

  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("pins after reset", timerOut, 2'h3);
    rd(TTU_T0_CTRL_IDX, 16'h0002);
    rd(TTU_T1_CTRL_IDX, 16'h0002);
    rd(TTU_T2_CTRL_IDX, 16'h0000);
    apb(1'b0, 10'h064, 16'h0000);
    chk("missing limit err", rdErr, 1'b1);
    apb(1'b1, TTU_T0_TALLY_IDX, 16'h1234);
    rd(TTU_T0_TALLY_IDX, 16'h1234);
    apb(1'b1, TTU_T0_LIMA_IDX, 16'h0003);
    // run-enable without the gate bit stays clear, so pin edges are ignored
    apb(1'b1, TTU_T0_CTRL_IDX, 16'h8005);
    rd(TTU_T0_CTRL_IDX, 16'h0005);
    edges(0, 2);
    rd(TTU_T0_TALLY_IDX, 16'h1234);
    // outside clock, single limit, free run
    apb(1'b1, TTU_T0_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T0_CTRL_IDX, 16'he005);
    rd(TTU_T0_CTRL_IDX, 16'ha005);
    edges(0, 3);
    chk("t0 requests", irqCnt[0], 1);
    chk("t0 low cycles", lowCnt, 1);
    rd(TTU_T0_TALLY_IDX, 16'h0000);
    rd(TTU_T0_CTRL_IDX, 16'ha025);
    // dual limits, halting after limit b
    apb(1'b1, TTU_T1_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T1_LIMA_IDX, 16'h0002);
    apb(1'b1, TTU_T1_LIMB_IDX, 16'h0003);
    apb(1'b1, TTU_T1_CTRL_IDX, 16'he006);
    edges(1, 2);
    rd(TTU_T1_CTRL_IDX, 16'hb026);
    chk("t1 pin on b", timerOut[1], 1'b0);
    edges(1, 3);
    rd(TTU_T1_CTRL_IDX, 16'h2026);
    chk("t1 pin on a", timerOut[1], 1'b1);
    chk("t1 requests", irqCnt[1], 2);
    apb(1'b1, TTU_T1_CTRL_IDX, 16'h2006);
    rd(TTU_T1_CTRL_IDX, 16'h2006);
    // timer 2 halts at its limit with run-enable cleared
    apb(1'b1, TTU_T2_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T2_LIMA_IDX, 16'h0005);
    apb(1'b1, TTU_T2_CTRL_IDX, 16'he000);
    repeat (40) @(posedge sys_clk);
    rd(TTU_T2_CTRL_IDX, 16'h2020);
    chk("t2 requests", irqCnt[2], 1);
    // gated internal clock: holds while the pin is low, counts while high
    apb(1'b1, TTU_T0_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T0_LIMA_IDX, 16'h0000);
    apb(1'b1, TTU_T0_CTRL_IDX, 16'hc001);
    repeat (40) @(posedge sys_clk);
    rd(TTU_T0_TALLY_IDX, 16'h0000);
    levelHold <= 2'h1;
    repeat (40) @(posedge sys_clk);
    levelHold <= 2'h0;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, TTU_T0_TALLY_IDX, 16'h0000);
    chk("gated count", rdVal[15:0] >= 16'h8 && rdVal[15:0] <= 16'hc, 1'b1);
    // timer 0 chained on timer 2; switch the clock source first so no quarter-rate tick slips in
    irqBase = irqCnt[2];
    levelHold <= 2'h1;
    apb(1'b1, TTU_T0_CTRL_IDX, 16'hc009);
    apb(1'b1, TTU_T0_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T2_TALLY_IDX, 16'h0000);
    apb(1'b1, TTU_T2_LIMA_IDX, 16'h0002);
    apb(1'b1, TTU_T2_CTRL_IDX, 16'he001);
    repeat (80) @(posedge sys_clk);
    apb(1'b1, TTU_T2_CTRL_IDX, 16'h4000);
    levelHold <= 2'h0;
    apb(1'b0, TTU_T0_TALLY_IDX, 16'h0000);
    chk("chained ticks", rdVal, irqCnt[2] - irqBase);
    chk("chained rate", rdVal[15:0] >= 16'h9 && rdVal[15:0] <= 16'hc, 1'b1);
    // edge restart on timer 1: idle until the first edge, each later edge clears
    apb(1'b1, TTU_T1_LIMA_IDX, 16'h0000);
    apb(1'b1, TTU_T1_TALLY_IDX, 16'h0100);
    apb(1'b1, TTU_T1_CTRL_IDX, 16'hc011);
    repeat (20) @(posedge sys_clk);
    rd(TTU_T1_TALLY_IDX, 16'h0100);
    edges(1, 1);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, TTU_T1_TALLY_IDX, 16'h0000);
    chk("restart count", rdVal[15:0] >= 16'h9 && rdVal[15:0] <= 16'hc, 1'b1);
    edges(1, 1);
    apb(1'b0, TTU_T1_TALLY_IDX, 16'h0000);
    chk("second restart", rdVal[15:0] <= 16'h1, 1'b1);
    // limit below count: timer 2 runs through 0xffff and wraps before its terminal
    apb(1'b1, TTU_T2_TALLY_IDX, 16'hfff0);
    apb(1'b1, TTU_T2_LIMA_IDX, 16'h0002);
    apb(1'b1, TTU_T2_CTRL_IDX, 16'hc000);
    repeat (30) @(posedge sys_clk);
    apb(1'b0, TTU_T2_TALLY_IDX, 16'h0000);
    chk("wrap pending", rdVal[15:0] >= 16'hfff5 && rdVal[15:0] <= 16'hfffb, 1'b1);
    repeat (80) @(posedge sys_clk);
    rd(TTU_T2_CTRL_IDX, 16'h0020);
    rd(TTU_T2_TALLY_IDX, 16'h0000);
    printVerdict();
  end

  // cut a hang short well past the expected run length
  initial
  begin
    #50000;
    errorCnt++;
    printVerdict();
  end
endmodule : tb_top
